// ===== ata_command_decoder.sv
// Task-file command decoder with Avalon-MM register access.
//
// Operation
// R1 - Check power in sleep: count 00h, interrupt.
// R2 - Check power when idle: count FFh, interrupt.
// R3 - Diagnostic 90h returns codes 01h-05h in error.
// R4 - True IDE failed slave reports 8Xh.
// R5 - Diagnostic self tests, drive select only.
// R6 - Format 50h fills head and cylinder with FFh.
// R7 - Format accepts one sector buffer, then discards.
// R8 - Format in LBA counts sectors, zero means 256.
// R9 - Erase C0h still accepted.
// R10 - CDh and 38h still erase first.
// R11 - Both alternate opcodes decode as one command.
// R12 - Reads decode as class 1.
// R13 - Format, buffer, long, sector, verify writes class 2.
// R14 - C5h and CDh decode as class 3.
// R15 - Extra commands 03h, 87h, F5h implemented.
// R16 - Drive-only commands ignore head bits.
// R17 - Marked registers are taken as parameters.
// R18 - 1Xh recalibrate, 7Xh seek with addressing.
// R19 - Host issues commands only while not busy.
// R20 - Class 1 raises busy within 400 ns.
// R21 - Class 2 drq within 700 us, busy drops.
// R22 - Class 3 drq within 20 ms, busy drops.
// R23 - Unknown opcode aborts with interrupt.
//
// Our own choices: the Avalon-MM register port and the address map.
`timescale 1ns/100ps
module ata_command_decoder #(
  parameter int DRQ2_LIMIT = ata_cmd_pkg::DRQ2_CYCLES,
  parameter int DRQ3_LIMIT = ata_cmd_pkg::DRQ3_CYCLES
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Avalon-MM slave.
  input wire logic [5:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Host interrupt request.
  output logic intrq,
  // Pins: true IDE strap and slave diagnostic failure.
  input wire logic true_ide_pin,
  input wire logic slave_fail_pin,
  // Self-test failures: formatter, buffer, ECC, processor.
  input wire logic [3:0] test_fail,
  // Media side.
  output ata_cmd_pkg::media_req_t media_req,
  output logic [31:0] wr_data_word,
  output logic wr_data_valid
);

  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_EXEC = 3'b001,
    S_PREP = 3'b010,
    S_XFER = 3'b011,
    S_FINISH = 3'b100
  } state_t;

  ////////////////////////////////////////////////////////////////////////////////

  function automatic ata_cmd_pkg::cmd_info_t decode(input logic [7:0] code);
    ata_cmd_pkg::cmd_info_t i;
    i = '{known: 1'b1, cls: 2'd1, op: ata_cmd_pkg::OP_NONE, use_head: 1'b0, lba_ok: 1'b0};
    case (code)
      8'hE5, 8'h98: i.op = ata_cmd_pkg::OP_CHKPWR; // R11
      8'h90: i.op = ata_cmd_pkg::OP_DIAG; // R5
      8'hC0: i.op = ata_cmd_pkg::OP_ERASE; // R9
      8'h50: begin
        i.op = ata_cmd_pkg::OP_FORMAT;
        i.cls = 2'd2; // R13
      end
      8'hEC: i.op = ata_cmd_pkg::OP_IDENT;
      8'hE3, 8'h97: i.op = ata_cmd_pkg::OP_IDLE; // R11
      8'hE1, 8'h95: i.op = ata_cmd_pkg::OP_IDLE_IMM; // R11
      8'h91: i.op = ata_cmd_pkg::OP_INIT_PARAM;
      8'hE4: i.op = ata_cmd_pkg::OP_RD_BUF; // R12
      8'hC4: i.op = ata_cmd_pkg::OP_RD_MULT; // R12
      8'h22, 8'h23: i.op = ata_cmd_pkg::OP_RD_LONG; // R12
      8'h20, 8'h21: i.op = ata_cmd_pkg::OP_RD_SECT; // R12
      8'h40, 8'h41: i.op = ata_cmd_pkg::OP_RD_VERIFY; // R12
      8'h03: i.op = ata_cmd_pkg::OP_SENSE; // R15
      8'hEF: i.op = ata_cmd_pkg::OP_SET_FEAT;
      8'hC6: i.op = ata_cmd_pkg::OP_SET_MULT;
      8'hE6, 8'h99: i.op = ata_cmd_pkg::OP_SLEEP; // R11
      8'hE2, 8'h96: i.op = ata_cmd_pkg::OP_STANDBY; // R11
      8'hE0, 8'h94: i.op = ata_cmd_pkg::OP_STANDBY_IMM; // R11
      8'h87: i.op = ata_cmd_pkg::OP_TRANSLATE; // R15
      8'hF5: i.op = ata_cmd_pkg::OP_WEAR; // R15
      8'hE8: begin
        i.op = ata_cmd_pkg::OP_WR_BUF;
        i.cls = 2'd2; // R13
      end
      8'h32, 8'h33: begin
        i.op = ata_cmd_pkg::OP_WR_LONG;
        i.cls = 2'd2; // R13
      end
      8'hC5: begin
        i.op = ata_cmd_pkg::OP_WR_MULT;
        i.cls = 2'd3; // R14
      end
      8'hCD: begin
        i.op = ata_cmd_pkg::OP_WR_MULT_NE;
        i.cls = 2'd3; // R14
      end
      8'h30, 8'h31: begin
        i.op = ata_cmd_pkg::OP_WR_SECT;
        i.cls = 2'd2; // R13
      end
      8'h38: begin
        i.op = ata_cmd_pkg::OP_WR_SECT_NE;
        i.cls = 2'd2; // R13
      end
      8'h3C: begin
        i.op = ata_cmd_pkg::OP_WR_VERIFY;
        i.cls = 2'd2; // R13
      end
      default: begin
        if (code[7:4] == 4'h1) begin
          i.op = ata_cmd_pkg::OP_RECAL; // R18
        end else if (code[7:4] == 4'h7) begin
          i.op = ata_cmd_pkg::OP_SEEK; // R18
        end else begin
          i.known = 1'b0;
        end
      end
    endcase
    // Drive-only commands drop the head bits.
    case (i.op)
      ata_cmd_pkg::OP_ERASE, ata_cmd_pkg::OP_FORMAT, ata_cmd_pkg::OP_INIT_PARAM,
      ata_cmd_pkg::OP_RD_MULT, ata_cmd_pkg::OP_RD_LONG, ata_cmd_pkg::OP_RD_SECT,
      ata_cmd_pkg::OP_RD_VERIFY, ata_cmd_pkg::OP_SEEK, ata_cmd_pkg::OP_TRANSLATE,
      ata_cmd_pkg::OP_WEAR, ata_cmd_pkg::OP_WR_LONG, ata_cmd_pkg::OP_WR_MULT,
      ata_cmd_pkg::OP_WR_MULT_NE, ata_cmd_pkg::OP_WR_SECT, ata_cmd_pkg::OP_WR_SECT_NE,
      ata_cmd_pkg::OP_WR_VERIFY: i.use_head = 1'b1; // R16
      default: i.use_head = 1'b0; // R16
    endcase
    i.lba_ok = i.use_head && (i.op != ata_cmd_pkg::OP_INIT_PARAM) &&
               (i.op != ata_cmd_pkg::OP_WEAR);
    return i;
  endfunction

  function automatic logic [8:0] sector_total(input logic [7:0] sc);
    return (sc == 8'h00) ? 9'h100 : {1'b0, sc}; // R8
  endfunction

  ////////////////////////////////////////////////////////////////////////////////

  logic [7:0] feature_param_reg;
  logic [7:0] sector_count_reg;
  logic [7:0] sector_number_reg;
  logic [15:0] cylinder_regs;
  logic [7:0] drive_head_reg;
  logic [7:0] error_reg;
  logic [7:0] feature_setting;
  logic [7:0] multiple_count;
  logic [7:0] sectors_per_track;
  logic [3:0] head_count;
  logic busy;
  logic drq;
  logic err_flag;
  state_t state;
  ata_cmd_pkg::cmd_info_t cur;
  ata_cmd_pkg::power_t power;
  logic [17:0] cnt;
  logic [6:0] word_cnt;
  logic [8:0] sectors_left;
  logic [1:0] sync_ide;
  logic [1:0] sync_slave;
  logic true_ide;
  logic slave_failed;
  logic [2:0] pin_sync [2];
  logic [1:0] pin_stable;

  logic wr_acc;
  logic rd_acc;
  logic launch;
  logic exec_end;
  logic prep_end;
  logic sector_end;
  logic [17:0] prep_last;
  ata_cmd_pkg::cmd_info_t new_info;
  logic [31:0] next_readdata;
  logic [7:0] status_byte;
  logic [7:0] diag_code;

  ////////////////////////////////////////////////////////////////////////////////

  // Async pins; a change counts once the last two stages agree.
  assign pin_stable = {slave_failed, true_ide};
  assign sync_ide = {pin_sync[0][2], pin_sync[0][1]};
  assign sync_slave = {pin_sync[1][2], pin_sync[1][1]};

  generate
    for (genvar p = 0; p < 2; p++) begin : g_pin
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          pin_sync[p] <= 3'b000;
        end else begin
          pin_sync[p] <= {pin_sync[p][1:0], (p == 0) ? true_ide_pin : slave_fail_pin};
        end
      end
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      true_ide <= 1'b0;
      slave_failed <= 1'b0;
    end else begin
      if (sync_ide[1] == sync_ide[0]) begin
        true_ide <= sync_ide[0];
      end
      if (sync_slave[1] == sync_slave[0]) begin
        slave_failed <= sync_slave[0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////

  // One wait state keeps read data registered.
  assign wr_acc = write && !waitrequest;
  assign rd_acc = read && !waitrequest;
  assign new_info = decode(writedata[7:0]);
  // Writes while busy are dropped, so a command never lands mid-flight.
  assign launch = wr_acc && (address[5:2] == ata_cmd_pkg::OFS_COMMAND[5:2]) && !busy &&
                  (!drive_head_reg[ata_cmd_pkg::DH_DRIVE] ||
                   writedata[7:0] == ata_cmd_pkg::CMD_DIAG); // R19 R5 R16
  assign status_byte = {busy, !busy, 2'b00, drq, 2'b00, err_flag};

  always_comb begin
    next_readdata = 32'h0000_0000;
    case (address[5:2])
      ata_cmd_pkg::OFS_FEATURE[5:2]: next_readdata[7:0] = feature_param_reg;
      ata_cmd_pkg::OFS_SECT_COUNT[5:2]: next_readdata[7:0] = sector_count_reg;
      ata_cmd_pkg::OFS_SECT_NUMBER[5:2]: next_readdata[7:0] = sector_number_reg;
      ata_cmd_pkg::OFS_CYLINDER[5:2]: next_readdata[15:0] = cylinder_regs;
      ata_cmd_pkg::OFS_DRIVE_HEAD[5:2]: next_readdata[7:0] = drive_head_reg;
      ata_cmd_pkg::OFS_COMMAND[5:2]: next_readdata[8:0] = {intrq, status_byte};
      ata_cmd_pkg::OFS_ERROR[5:2]: next_readdata[7:0] = error_reg;
      ata_cmd_pkg::OFS_ALT_STATUS[5:2]: next_readdata[8:0] = {intrq, status_byte};
      ata_cmd_pkg::OFS_SETUP[5:2]: next_readdata[29:0] =
        {pin_stable, head_count, sectors_per_track, multiple_count, feature_setting};
      default: next_readdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      waitrequest <= 1'b1;
      readdata <= 32'h0000_0000;
    end else begin
      waitrequest <= !((read || write) && waitrequest);
      if (read && waitrequest) begin
        readdata <= next_readdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////

  assign exec_end = (state == S_EXEC) && (cnt == 18'(ata_cmd_pkg::EXEC_CYCLES - 1));
  assign prep_last = (cur.cls == 2'd3) ? 18'(DRQ3_LIMIT - 1) : 18'(DRQ2_LIMIT - 1);
  assign prep_end = (state == S_PREP) && (cnt == prep_last); // R21 R22
  assign sector_end = (state == S_XFER) && wr_acc &&
                      (address[5:2] == ata_cmd_pkg::OFS_DATA[5:2]) &&
                      (word_cnt == 7'(ata_cmd_pkg::SECTOR_WORDS - 1));

  // Task file; check power overwrites the sector count.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      feature_param_reg <= 8'h00;
      sector_count_reg <= ata_cmd_pkg::SC_RESET;
      sector_number_reg <= ata_cmd_pkg::SN_RESET;
      cylinder_regs <= 16'h0000;
      drive_head_reg <= ata_cmd_pkg::DH_RESET;
    end else if (exec_end && cur.op == ata_cmd_pkg::OP_CHKPWR) begin
      sector_count_reg <= (power == ata_cmd_pkg::PWR_IDLE) ?
        ata_cmd_pkg::PWR_REPORT_IDLE : ata_cmd_pkg::PWR_REPORT_SLEEP; // R1 R2
    end else if (wr_acc && !busy) begin
      case (address[5:2])
        ata_cmd_pkg::OFS_FEATURE[5:2]: feature_param_reg <= writedata[7:0];
        ata_cmd_pkg::OFS_SECT_COUNT[5:2]: sector_count_reg <= writedata[7:0];
        ata_cmd_pkg::OFS_SECT_NUMBER[5:2]: sector_number_reg <= writedata[7:0];
        ata_cmd_pkg::OFS_CYLINDER[5:2]: cylinder_regs <= writedata[15:0];
        ata_cmd_pkg::OFS_DRIVE_HEAD[5:2]: drive_head_reg <= writedata[7:0];
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state <= S_IDLE;
      busy <= 1'b0;
      drq <= 1'b0;
      cnt <= 18'h0_0000;
      word_cnt <= 7'h00;
      sectors_left <= 9'h000;
      cur <= '0;
    end else begin
      case (state)
        S_IDLE: begin
          cnt <= 18'h0_0000;
          word_cnt <= 7'h00;
          if (launch) begin
            busy <= 1'b1; // R20
            cur <= new_info;
            if (!new_info.known) begin
              state <= S_FINISH; // R23
            end else if (new_info.cls == 2'd1) begin
              state <= S_EXEC; // R12
            end else begin
              state <= S_PREP; // R21 R22
            end
            case (new_info.op)
              ata_cmd_pkg::OP_WR_MULT, ata_cmd_pkg::OP_WR_MULT_NE, ata_cmd_pkg::OP_WR_SECT,
              ata_cmd_pkg::OP_WR_SECT_NE, ata_cmd_pkg::OP_WR_VERIFY:
                sectors_left <= sector_total(sector_count_reg);
              default: sectors_left <= 9'h001; // R7
            endcase
          end
        end
        S_EXEC: begin
          cnt <= cnt + 18'h0_0001;
          if (exec_end) begin
            state <= S_FINISH;
          end
        end
        S_PREP: begin
          cnt <= cnt + 18'h0_0001;
          if (prep_end) begin
            drq <= 1'b1; // R21 R22
            busy <= 1'b0; // R21 R22
            state <= S_XFER;
          end
        end
        S_XFER: begin
          if (wr_acc && address[5:2] == ata_cmd_pkg::OFS_DATA[5:2]) begin
            word_cnt <= word_cnt + 7'h01;
          end
          if (sector_end) begin
            sectors_left <= sectors_left - 9'h001;
            if (sectors_left == 9'h001) begin
              drq <= 1'b0;
              busy <= 1'b1;
              cnt <= 18'h0_0000;
              state <= S_EXEC;
            end
          end
        end
        S_FINISH: begin
          busy <= 1'b0;
          state <= S_IDLE;
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////

  // Diagnostic result: first failing unit wins; a failed slave in true IDE sets 8Xh.
  always_comb begin
    if (test_fail[0]) begin
      diag_code = ata_cmd_pkg::DIAG_FORMATTER; // R3
    end else if (test_fail[1]) begin
      diag_code = ata_cmd_pkg::DIAG_BUFFER; // R3
    end else if (test_fail[2]) begin
      diag_code = ata_cmd_pkg::DIAG_ECC; // R3
    end else if (test_fail[3]) begin
      diag_code = ata_cmd_pkg::DIAG_CPU; // R3
    end else begin
      diag_code = ata_cmd_pkg::DIAG_OK; // R3
    end
    if (true_ide && slave_failed) begin
      diag_code = {ata_cmd_pkg::DIAG_SLAVE_NIB, diag_code[3:0]}; // R4
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      error_reg <= 8'h00;
      err_flag <= 1'b0;
    end else if (launch) begin
      error_reg <= 8'h00;
      err_flag <= 1'b0;
    end else if (state == S_FINISH && !cur.known) begin
      error_reg <= ata_cmd_pkg::ERR_ABORT; // R23
      err_flag <= 1'b1; // R23
    end else if (exec_end && cur.op == ata_cmd_pkg::OP_DIAG) begin
      error_reg <= diag_code; // R3 R5
      err_flag <= (diag_code != ata_cmd_pkg::DIAG_OK);
    end
  end

  // Completion sets the request; a status read clears it; set wins.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      intrq <= 1'b0;
    end else if (state == S_FINISH) begin
      intrq <= 1'b1; // R1 R2 R23
    end else if (launch || (rd_acc && address[5:2] == ata_cmd_pkg::OFS_COMMAND[5:2])) begin
      intrq <= 1'b0;
    end
  end

  // Power mode and parameters set by the setup commands.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      power <= ata_cmd_pkg::PWR_IDLE;
      feature_setting <= 8'h00;
      multiple_count <= 8'h00;
      sectors_per_track <= 8'h00;
      head_count <= 4'h0;
    end else if (exec_end) begin
      case (cur.op)
        ata_cmd_pkg::OP_SLEEP: power <= ata_cmd_pkg::PWR_SLEEP;
        ata_cmd_pkg::OP_STANDBY, ata_cmd_pkg::OP_STANDBY_IMM: power <= ata_cmd_pkg::PWR_STANDBY;
        ata_cmd_pkg::OP_IDLE, ata_cmd_pkg::OP_IDLE_IMM: power <= ata_cmd_pkg::PWR_IDLE;
        ata_cmd_pkg::OP_SET_FEAT: feature_setting <= feature_param_reg; // R17
        ata_cmd_pkg::OP_SET_MULT: multiple_count <= sector_count_reg; // R17
        ata_cmd_pkg::OP_INIT_PARAM: begin
          sectors_per_track <= sector_count_reg; // R17
          head_count <= drive_head_reg[3:0]; // R17
        end
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////

  // Media request: one-cycle pulse when non-format writes raise data request, and at the end of execution for head-using commands, recalibrate and format.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      media_req <= '0;
    end else begin
      media_req.valid <= 1'b0;
      if ((prep_end && cur.op != ata_cmd_pkg::OP_FORMAT) ||
          (exec_end && cur.op != ata_cmd_pkg::OP_FORMAT && cur.use_head) ||
          (exec_end && cur.op == ata_cmd_pkg::OP_RECAL) ||
          (exec_end && cur.op == ata_cmd_pkg::OP_FORMAT)) begin
        media_req.valid <= 1'b1; // R6 R9 R15 R18
        media_req.op <= cur.op;
        media_req.drive <= drive_head_reg[ata_cmd_pkg::DH_DRIVE];
        media_req.head <= cur.use_head ? drive_head_reg[3:0] : 4'h0; // R16
        media_req.lba <= cur.lba_ok && drive_head_reg[ata_cmd_pkg::DH_LBA]; // R18
        media_req.sector <= sector_number_reg;
        media_req.cylinder <= cylinder_regs;
        media_req.erase_first <= 1'b1; // R10
        media_req.fill <= ata_cmd_pkg::FORMAT_FILL; // R6
        if (cur.op == ata_cmd_pkg::OP_FORMAT && !drive_head_reg[ata_cmd_pkg::DH_LBA]) begin
          media_req.count <= sector_total(sectors_per_track); // R6
        end else begin
          media_req.count <= sector_total(sector_count_reg); // R8
        end
      end
    end
  end

  // Write data goes to the media side; format data is taken and thrown away.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_data_word <= 32'h0000_0000;
      wr_data_valid <= 1'b0;
    end else begin
      wr_data_valid <= wr_acc && (state == S_XFER) &&
                       (address[5:2] == ata_cmd_pkg::OFS_DATA[5:2]) &&
                       (cur.op != ata_cmd_pkg::OP_FORMAT); // R7
      if (wr_acc && address[5:2] == ata_cmd_pkg::OFS_DATA[5:2]) begin
        wr_data_word <= writedata;
      end
    end
  end

endmodule

// ===== ata_cmd_pkg.sv
// Constants, opcodes and carrier types for the task-file command decoder.
package ata_cmd_pkg;

  // Clock and timing.
  localparam int CLK_HZ = 10_000_000;
  localparam int DRQ2_MAX_US = 700;
  localparam int DRQ3_MAX_MS = 20;
  localparam int DRQ2_CYCLES = DRQ2_MAX_US * (CLK_HZ / 1_000_000);
  localparam int DRQ3_CYCLES = DRQ3_MAX_MS * (CLK_HZ / 1_000);
  localparam int EXEC_CYCLES = 4;
  localparam int SECTOR_WORDS = 128;

  // Register byte offsets.
  localparam logic [5:0] OFS_FEATURE = 6'h00;
  localparam logic [5:0] OFS_SECT_COUNT = 6'h04;
  localparam logic [5:0] OFS_SECT_NUMBER = 6'h08;
  localparam logic [5:0] OFS_CYLINDER = 6'h0C;
  localparam logic [5:0] OFS_DRIVE_HEAD = 6'h10;
  localparam logic [5:0] OFS_COMMAND = 6'h14;
  localparam logic [5:0] OFS_ERROR = 6'h18;
  localparam logic [5:0] OFS_ALT_STATUS = 6'h1C;
  localparam logic [5:0] OFS_SETUP = 6'h20;
  localparam logic [5:0] OFS_DATA = 6'h24;

  // Field positions.
  localparam int ST_BUSY = 7;
  localparam int ST_READY = 6;
  localparam int ST_DRQ = 3;
  localparam int ST_ERR = 0;
  localparam int DH_LBA = 6;
  localparam int DH_DRIVE = 4;
  localparam int ST_INTRQ = 8;

  // Values.
  localparam logic [7:0] ERR_ABORT = 8'h04;
  localparam logic [7:0] DIAG_OK = 8'h01;
  localparam logic [7:0] DIAG_FORMATTER = 8'h02;
  localparam logic [7:0] DIAG_BUFFER = 8'h03;
  localparam logic [7:0] DIAG_ECC = 8'h04;
  localparam logic [7:0] DIAG_CPU = 8'h05;
  localparam logic [3:0] DIAG_SLAVE_NIB = 4'h8;
  localparam logic [7:0] PWR_REPORT_SLEEP = 8'h00;
  localparam logic [7:0] PWR_REPORT_IDLE = 8'hFF;
  localparam logic [7:0] FORMAT_FILL = 8'hFF;
  localparam logic [7:0] DH_RESET = 8'hA0;
  localparam logic [7:0] SC_RESET = 8'h01;
  localparam logic [7:0] SN_RESET = 8'h01;

  // Command codes.
  localparam logic [7:0] CMD_DIAG = 8'h90;

  typedef enum logic [4:0] {
    OP_NONE = 5'h00, OP_CHKPWR = 5'h01, OP_DIAG = 5'h02, OP_ERASE = 5'h03,
    OP_FORMAT = 5'h04, OP_IDENT = 5'h05, OP_IDLE = 5'h06, OP_IDLE_IMM = 5'h07,
    OP_INIT_PARAM = 5'h08, OP_RD_BUF = 5'h09, OP_RD_MULT = 5'h0A, OP_RD_LONG = 5'h0B,
    OP_RD_SECT = 5'h0C, OP_RD_VERIFY = 5'h0D, OP_RECAL = 5'h0E, OP_SENSE = 5'h0F,
    OP_SEEK = 5'h10, OP_SET_FEAT = 5'h11, OP_SET_MULT = 5'h12, OP_SLEEP = 5'h13,
    OP_STANDBY = 5'h14, OP_STANDBY_IMM = 5'h15, OP_TRANSLATE = 5'h16, OP_WEAR = 5'h17,
    OP_WR_BUF = 5'h18, OP_WR_LONG = 5'h19, OP_WR_MULT = 5'h1A, OP_WR_MULT_NE = 5'h1B,
    OP_WR_SECT = 5'h1C, OP_WR_SECT_NE = 5'h1D, OP_WR_VERIFY = 5'h1E
  } op_t;

  typedef enum logic [1:0] {
    PWR_IDLE = 2'b00, PWR_STANDBY = 2'b01, PWR_SLEEP = 2'b10
  } power_t;

  typedef struct packed {
    logic known;
    logic [1:0] cls;
    op_t op;
    logic use_head;
    logic lba_ok;
  } cmd_info_t;

  typedef struct packed {
    logic valid;
    op_t op;
    logic drive;
    logic [3:0] head;
    logic lba;
    logic [7:0] sector;
    logic [15:0] cylinder;
    logic [8:0] count;
    logic erase_first;
    logic [7:0] fill;
  } media_req_t;

endpackage

// ===== ata_cmd_chk_asserts.sv
// Port checks for the command decoder.
`timescale 1ns/100ps
module ata_cmd_chk (
  // Watched ports.
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [5:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic waitrequest,
  input wire logic intrq,
  input wire ata_cmd_pkg::media_req_t media_req
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic go;
  logic [7:0] op;
  assign go = write && !waitrequest && address == ata_cmd_pkg::OFS_COMMAND;
  assign op = writedata[7:0];
  property p_wait; (read || write) && waitrequest |=> !waitrequest; endproperty
  a_wait: assert property (p_wait) else $error("no answer");
  property p_one; !waitrequest |=> waitrequest; endproperty
  a_one: assert property (p_one) else $error("wait low twice");
  property p_abort; go && op == 8'h00 |=> !intrq ##[1:2] intrq; endproperty
  a_abort: assert property (p_abort) else $error("no abort irq");
  property p_rd;
    go && op inside {8'h20, 8'h21, 8'h22, 8'h23, 8'h40, 8'h41, 8'hC4, 8'hE4}
      |=> !intrq [*4] ##[1:3] intrq;
  endproperty
  a_rd: assert property (p_rd) else $error("read timing");
  property p_alt;
    go && op inside {8'hE5, 8'h98, 8'hE6, 8'h99} |=> !intrq [*4] ##[1:3] intrq;
  endproperty
  a_alt: assert property (p_alt) else $error("alt timing");
  property p_erase; media_req.valid |-> media_req.erase_first; endproperty
  a_erase: assert property (p_erase) else $error("no erase");
  property p_fill;
    media_req.valid && media_req.op == ata_cmd_pkg::OP_FORMAT |-> media_req.fill == 8'hFF;
  endproperty
  a_fill: assert property (p_fill) else $error("bad fill");
  property p_head;
    media_req.valid && media_req.op == ata_cmd_pkg::OP_RECAL |-> media_req.head == 4'h0;
  endproperty
  a_head: assert property (p_head) else $error("head used");
endmodule

// ===== host_model.sv
// Host adapter model: Avalon master for task-file access.
`timescale 1ns/100ps
module host_model (
  // Bus clock.
  input wire logic clk,
  // Avalon master.
  output logic [5:0] address,
  output logic read,
  output logic write,
  output logic [31:0] writedata,
  input wire logic [31:0] readdata,
  input wire logic waitrequest
);
  initial begin
    address = 6'h00;
    read = 1'b0;
    write = 1'b0;
    writedata = 32'h0000_0000;
  end
  // The request holds until waitrequest is sampled low.
  task automatic acc(input logic rd, input logic [5:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge clk);
    address <= a;
    writedata <= d;
    read <= rd;
    write <= !rd;
    do @(posedge clk); while (waitrequest !== 1'b0);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task automatic sector();
    logic [31:0] q;
    for (int i = 0; i < ata_cmd_pkg::SECTOR_WORDS; i++) begin
      acc(1'b0, ata_cmd_pkg::OFS_DATA, 32'(i), q);
    end
  endtask
endmodule

// ===== ata_command_decoder_tb.sv
// Self-checking bench for the command decoder.
`timescale 1ns/100ps
module ata_command_decoder_tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic ide = 1'b0;
  logic sfail = 1'b0;
  logic [3:0] tf = 4'h0;
  logic [5:0] address;
  logic read;
  logic write;
  logic [31:0] writedata;
  logic [31:0] readdata;
  logic waitrequest;
  logic intrq;
  logic wdv;
  logic [31:0] wdw;
  ata_cmd_pkg::media_req_t mr;
  logic [31:0] q;
  int num_errors = 0;
  int n_tests = 0;
  int cyc = 0;
  int words = 0;
  initial forever #50 clk = ~clk;
  host_model hm (.clk(clk), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest));
  // Small data-request limits keep the run short.
  ata_command_decoder #(.DRQ2_LIMIT(8), .DRQ3_LIMIT(12)) uut (.clk(clk), .rst_n(rst_n),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest), .intrq(intrq), .true_ide_pin(ide),
    .slave_fail_pin(sfail), .test_fail(tf), .media_req(mr), .wr_data_word(wdw),
    .wr_data_valid(wdv));
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (wdv === 1'b1) words <= words + 1;
    if (cyc == 8000) begin
      num_errors = num_errors + 1;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("tests %0d, errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", s, e, g);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    hm.acc(1'b0, a, d, q);
  endtask
  task automatic rd(input logic [5:0] a);
    hm.acc(1'b1, a, 32'h0000_0000, q);
  endtask
  // Waits for the interrupt; the status read clears it.
  task automatic fin();
    for (int n = 0; n < 100 && intrq !== 1'b1; n++) @(posedge clk);
    rd(ata_cmd_pkg::OFS_COMMAND);
  endtask
  task automatic cmd(input logic [7:0] op);
    wr(ata_cmd_pkg::OFS_COMMAND, 32'(op));
    fin();
  endtask
  task automatic xfer(input logic [7:0] op);
    wr(ata_cmd_pkg::OFS_COMMAND, 32'(op));
    rd(ata_cmd_pkg::OFS_COMMAND);
    chk("busy", 32'h0000_0080, 32'(q[7:0]));
    for (int n = 0; n < 40 && q[3] !== 1'b1; n++) rd(ata_cmd_pkg::OFS_COMMAND);
    chk("drq", 32'h0000_0048, 32'(q[7:0]));
    hm.sector();
    fin();
  endtask
  task automatic mop(input logic [7:0] c, input ata_cmd_pkg::op_t o, input logic [3:0] h);
    cmd(c);
    chk("op", 32'(o), 32'(mr.op));
    chk("head", 32'(h), 32'(mr.head));
  endtask
  task automatic t_reads();
    logic [7:0] c [8] = '{8'h20, 8'h21, 8'h22, 8'h23, 8'h40, 8'h41, 8'hC4, 8'hE4};
    foreach (c[i]) begin
      cmd(c[i]);
      chk("read status", 32'h0000_0040, 32'(q[7:0]));
    end
    $display("reads done");
  endtask
  task automatic t_diag();
    for (int i = 0; i < 5; i++) begin
      tf <= (i == 0) ? 4'h0 : 4'(1 << (i - 1));
      cmd(8'h90);
      rd(ata_cmd_pkg::OFS_ERROR);
      chk("diag", 32'(i + 1), q);
    end
    tf <= 4'h0;
    ide <= 1'b1;
    sfail <= 1'b1;
    wr(ata_cmd_pkg::OFS_DRIVE_HEAD, 32'h0000_00AF);
    cmd(8'h90);
    rd(ata_cmd_pkg::OFS_ERROR);
    chk("slave", 32'h0000_0008, 32'(q[7:4]));
    ide <= 1'b0;
    sfail <= 1'b0;
    $display("diag done");
  endtask
  task automatic t_abort();
    cmd(8'h00);
    chk("abort status", 32'h0000_0041, 32'(q[7:0]));
    rd(ata_cmd_pkg::OFS_ERROR);
    chk("abort error", 32'h0000_0004, q);
    $display("abort done");
  endtask
  task automatic t_write();
    int w0;
    w0 = words;
    wr(ata_cmd_pkg::OFS_DRIVE_HEAD, 32'h0000_00E5);
    wr(ata_cmd_pkg::OFS_SECT_COUNT, 32'h0000_0000);
    xfer(8'h50);
    chk("fmt op", 32'(ata_cmd_pkg::OP_FORMAT), 32'(mr.op));
    chk("fmt count", 32'h0000_0100, 32'(mr.count));
    chk("fmt words", 32'(w0), 32'(words));
    wr(ata_cmd_pkg::OFS_SECT_COUNT, 32'h0000_0001);
    xfer(8'hCD);
    chk("mult op", 32'(ata_cmd_pkg::OP_WR_MULT_NE), 32'(mr.op));
    chk("erase", 32'h0000_0001, 32'(mr.erase_first));
    chk("mult words", 32'(w0 + 128), 32'(words));
    chk("last word", 32'h0000_007F, wdw);
    $display("write done");
  endtask
  task automatic t_power();
    wr(ata_cmd_pkg::OFS_DRIVE_HEAD, 32'h0000_00A3);
    mop(8'hC0, ata_cmd_pkg::OP_ERASE, 4'h3);
    mop(8'h7A, ata_cmd_pkg::OP_SEEK, 4'h3);
    mop(8'h1F, ata_cmd_pkg::OP_RECAL, 4'h0);
    cmd(8'h98);
    rd(ata_cmd_pkg::OFS_SECT_COUNT);
    chk("idle power", 32'h0000_00FF, q);
    cmd(8'h99);
    cmd(8'hE5);
    rd(ata_cmd_pkg::OFS_SECT_COUNT);
    chk("sleep power", 32'h0000_0000, q);
    $display("power done");
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    t_reads();
    t_diag();
    t_abort();
    t_write();
    t_power();
    stop_test();
  end
endmodule
bind ata_command_decoder ata_cmd_chk chk_i (.clk(clk), .rst_n(rst_n), .address(address),
  .read(read), .write(write), .writedata(writedata), .waitrequest(waitrequest),
  .intrq(intrq), .media_req(media_req));
